//--- descriptor_ring_engine_tb_top.sv
// self-checking bench for the ring engine against the shared-memory model
`timescale 1ns/1ps
module descriptor_ring_engine_tb_top;
  import ring_pkg::*;
  logic core_clk, rst_b, ce, reg_wr, reg_rd, elem_ready, done_valid, slow;
  logic mem_req_valid, mem_req_ready, mem_rsp_valid, elem_valid, done_ready, used_notify;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_rdata, done_len, rd_q;
  mem_req_type mem_req;
  elem_type elem;
  int n_errors = 0;
  int checks = 0;
  int n_notify = 0;
  ring_engine ring_engine_i (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_req_valid(mem_req_valid), .mem_req(mem_req), .mem_req_ready(mem_req_ready),
    .mem_rsp_valid(mem_rsp_valid), .mem_rdata(mem_rdata), .elem_valid(elem_valid),
    .elem(elem), .elem_ready(elem_ready), .done_valid(done_valid), .done_len(done_len),
    .done_ready(done_ready), .used_notify(used_notify));
  ring_mem_model ring_mem_model_i (.core_clk(core_clk), .rst_b(rst_b), .slow(slow),
    .mem_req_valid(mem_req_valid), .mem_req(mem_req), .mem_req_ready(mem_req_ready),
    .mem_rsp_valid(mem_rsp_valid), .mem_rdata(mem_rdata));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (used_notify === 1'b1) n_notify++;
  end
  task automatic check(input logic [127:0] s, input logic [127:0] e, input string m);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, s, e);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic put(input logic [11:0] a, input logic [31:0] d);
    ring_mem_model_i.mem[a[9:2]] = d;
  endtask
  function automatic logic [31:0] mw(input logic [11:0] a);
    return ring_mem_model_i.mem[a[9:2]];
  endfunction
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask
  task automatic take_elem(input logic [31:0] a, input logic [31:0] len, input logic wr,
                           input logic last, input logic [15:0] id);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (elem_valid !== 1'b1 && n < 300);
    check(elem_valid, 1'b1, "element offered");
    check(elem, {32'h0000_0000, a, len, id, wr, last}, "element");
    repeat (2) @(posedge core_clk);
    elem_ready <= 1'b1;
    @(posedge core_clk);
    elem_ready <= 1'b0;
  endtask
  task automatic finish_buf(input logic [31:0] len, input int exp_n);
    int n;
    int base;
    n = 0;
    base = n_notify;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (done_ready !== 1'b1 && n < 300);
    check(done_ready, 1'b1, "completion offered");
    @(posedge core_clk);
    done_valid <= 1'b1;
    done_len <= len;
    @(posedge core_clk);
    done_valid <= 1'b0;
    repeat (60) @(posedge core_clk);
    check(n_notify - base, exp_n, "notify count");
  endtask
  task automatic test_regs();
    reg_read(OFF_QSIZE);
    check(rd_q, QSIZE_RST, "qsize reset");
    reg_read(OFF_STATE);
    check(rd_q[1:0], 2'b11, "wrap reset");
    reg_write(OFF_QSIZE, 32'h0000_9000);
    reg_read(OFF_QSIZE);
    check(rd_q, QSIZE_MAX, "qsize clamp");
    // a write while the clock enable is low must leave the register untouched
    @(posedge core_clk);
    ce <= 1'b0;
    reg_write(OFF_QSIZE, 32'h0000_0010);
    ce <= 1'b1;
    reg_read(OFF_QSIZE);
    check(rd_q, QSIZE_MAX, "frozen write");
    reg_write(OFF_STATUS, 32'hffff_ffff);
    reg_read(OFF_STATUS);
    check(rd_q, 32'h0000_0000, "status write");
    reg_read(8'h3c);
    check(rd_q, 32'h0000_0000, "unmapped");
    $display("test regs done");
  endtask
  task automatic test_split();
    reg_write(OFF_QSIZE, 32'h0000_0004);
    reg_write(OFF_DRV_BASE, 32'h0000_0100);
    reg_write(OFF_DEV_BASE, 32'h0000_0200);
    put(12'h000, 32'h0000_1000);
    put(12'h008, 32'h0000_0010);
    put(12'h00c, {16'h0001, DESC_F_NEXT});
    put(12'h010, 32'h0000_2000);
    put(12'h018, 32'h0000_0020);
    put(12'h01c, {16'h0000, DESC_F_WRITE});
    put(12'h100, 32'h0001_0000);
    reg_write(OFF_CTRL, 32'h0000_0001);
    reg_write(OFF_BELL, 32'h0000_0001);
    take_elem(32'h0000_1000, 32'h0000_0010, 1'b0, 1'b0, 16'h0000);
    take_elem(32'h0000_2000, 32'h0000_0020, 1'b1, 1'b1, 16'h0000);
    finish_buf(32'h0000_0008, 1);
    check(mw(12'h208), 32'h0000_0008, "used len");
    check(mw(12'h200) >> 16, 32'h0000_0001, "used idx");
    put(12'h020, 32'h0000_3000);
    put(12'h028, 32'h0000_0040);
    put(12'h02c, {16'h0000, DESC_F_WRITE});
    // head posted but index not advanced: must stay invisible
    put(12'h104, 32'h0002_0000);
    put(12'h100, 32'h0001_0001);
    reg_write(OFF_BELL, 32'h0000_0001);
    repeat (40) @(posedge core_clk);
    #1;
    check(elem_valid, 1'b0, "early fetch");
    put(12'h100, 32'h0002_0001);
    reg_write(OFF_BELL, 32'h0000_0001);
    take_elem(32'h0000_3000, 32'h0000_0040, 1'b1, 1'b1, 16'h0002);
    finish_buf(32'h0000_0040, 0);
    check(mw(12'h20c), 32'h0000_0002, "used id");
    reg_read(OFF_STATUS);
    check(rd_q, 32'h0002_0002, "status");
    // driver turns used notifications back on and looks at the used index again
    put(12'h100, 32'h0002_0000);
    check(mw(12'h200) >> 16, 32'h0000_0002, "used idx recheck");
    $display("test split done");
  endtask
  task automatic test_packed();
    @(posedge core_clk);
    slow <= 1'b1;
    reg_write(OFF_CTRL, 32'h0000_0000);
    reg_write(OFF_QSIZE, 32'h0000_0002);
    reg_write(OFF_DESC_BASE, 32'h0000_0300);
    reg_write(OFF_DRV_BASE, 32'h0000_0380);
    put(12'h300, 32'h0000_4000);
    put(12'h308, 32'h0000_0008);
    put(12'h30c, 32'h0082_0005);
    put(12'h310, 32'h0000_5000);
    put(12'h318, 32'h0000_0004);
    put(12'h31c, 32'h0080_0006);
    reg_write(OFF_CTRL, 32'h0000_0003);
    reg_write(OFF_BELL, 32'h0000_0001);
    take_elem(32'h0000_4000, 32'h0000_0008, 1'b1, 1'b1, 16'h0005);
    finish_buf(32'h0000_0008, 1);
    check(mw(12'h30c), 32'h8082_0005, "used flags");
    check(mw(12'h308), 32'h0000_0008, "used len");
    take_elem(32'h0000_5000, 32'h0000_0004, 1'b0, 1'b1, 16'h0006);
    finish_buf(32'h0000_0000, 1);
    check(mw(12'h31c), 32'h8080_0006, "used flags last");
    reg_read(OFF_STATE);
    check(rd_q[1:0], 2'b00, "wraps toggled");
    check(elem_valid, 1'b0, "stale slot");
    // second lap: the driver counter is now 0, so avail clear and used set
    put(12'h300, 32'h0000_7000);
    put(12'h308, 32'h0000_0010);
    put(12'h30c, 32'h8000_0007);
    reg_write(OFF_BELL, 32'h0000_0001);
    take_elem(32'h0000_7000, 32'h0000_0010, 1'b0, 1'b1, 16'h0007);
    finish_buf(32'h0000_0000, 1);
    check(mw(12'h30c), 32'h0000_0007, "used flags lap two");
    $display("test packed done");
  endtask
  initial begin
    ce = 1'b1;
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    elem_ready = 1'b0;
    done_valid = 1'b0;
    done_len = 32'h0000_0000;
    slow = 1'b0;
    for (int i = 0; i < 256; i++) begin
      ring_mem_model_i.mem[i] = 32'h0000_0000;
    end
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    test_regs();
    test_split();
    test_packed();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    close_out();
  end
endmodule // descriptor_ring_engine_tb_top

//--- ring_engine.sv
// device end of a descriptor ring queue: fetches chains, streams elements, posts completions
//
// Behaviour
// - split queue holds at most 32768 entries; 16-bit index tells full from empty.
// - buffer has one or more elements, readable ones before writable ones.
// - heads go to slot index plus added modulo size, invisible until index update.
// - ring indices only increment and wrap naturally modulo 65536.
// - device may fetch chains and their memory once it sees the new index.
// - after using a chain, device sends used notification unless suppressed.
// - packed queue has no more than 32768 descriptors.
// - packed completion writes used descriptor with buffer id over available slot, then notifies.
// - device reads packed descriptors in order and writes used ones in completion order.
// - driver and device each keep a one-bit wrap counter starting at 1.
// - device toggles its wrap counter after marking the last descriptor used.
// - device completes with both used and available flags equal to its counter.
// - device writes only its own suppression area, reads only the driver's.
// - flag value 2 marks element device write-only, otherwise read-only.
// - flag value 1 marks that the buffer continues in another descriptor.
`timescale 1ns/1ps
module ring_engine (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic mem_req_valid,
  output ring_pkg::mem_req_type mem_req,
  input wire logic mem_req_ready,
  input wire logic mem_rsp_valid,
  input wire logic [31:0] mem_rdata,
  output logic elem_valid,
  output ring_pkg::elem_type elem,
  input wire logic elem_ready,
  input wire logic done_valid,
  input wire logic [31:0] done_len,
  output logic done_ready,
  output logic used_notify
);
  import ring_pkg::*;

  typedef struct packed {
    st_type st;
    logic [2:0] ctrl;
    logic [15:0] qsize;
    logic [31:0] desc_base;
    logic [31:0] drv_base;
    logic [31:0] dev_base;
    logic bell;
    logic [15:0] avail_idx;
    logic [15:0] head;
    logic [15:0] nxt;
    logic [15:0] bid;
    logic [15:0] fl;
    logic [15:0] ev;
    logic [1:0] w;
    logic [15:0] cnt;
    logic seen_wr;
    logic err;
    logic [31:0] done_len;
    logic notify;
    logic [31:0] rdata;
    mem_req_type rq;
    logic rq_v;
    logic rs_w;
    elem_type el;
  } eng_type;

  eng_type q;
  eng_type d;
  logic pk;
  logic en;
  logic evt;
  logic fin;
  logic mst;
  logic [31:0] ra;
  logic [31:0] rwd;
  logic [3:0] rbe;
  logic rwr;
  logic rd_adv;
  logic us_adv;
  logic [15:0] us_step;
  logic [15:0] rd_idx;
  logic [15:0] rd_pos;
  logic rd_wrap;
  logic [15:0] us_idx;
  logic [15:0] us_pos;
  logic us_wrap;
  logic [15:0] dflags;
  logic [15:0] uflags;
  logic [15:0] hslot;

  assign pk = q.ctrl[CTRL_PACKED];
  assign en = q.ctrl[CTRL_EN];
  assign evt = q.ctrl[CTRL_EVT];
  assign dflags = mem_rdata[31:16];
  // ring slot of the next head; its low bit picks the half word of the fetched ring word
  assign hslot = slot(rd_idx, q.qsize);

  always_comb begin
    uflags = '0;
    uflags[DESC_F_AVAIL_BIT] = us_wrap;
    uflags[DESC_F_USED_BIT] = us_wrap;
    if (q.done_len != '0) begin
      uflags = uflags | DESC_F_WRITE;
    end
  end

  // fetch cursor: split index of the next head to fetch, packed read position
  ring_cursor #(.W(16)) u_fetch (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ce(ce),
    .clr(~en),
    .adv(rd_adv),
    .step(16'h0001),
    .qsize(q.qsize),
    .idx(rd_idx),
    .pos(rd_pos),
    .wrap(rd_wrap)
  );

  // completion cursor: split used index, packed used position and device wrap counter
  ring_cursor #(.W(16)) u_used (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ce(ce),
    .clr(~en),
    .adv(us_adv),
    .step(us_step),
    .qsize(q.qsize),
    .idx(us_idx),
    .pos(us_pos),
    .wrap(us_wrap)
  );

  always_comb begin
    d = q;
    d.notify = 1'b0;
    fin = 1'b0;
    mst = 1'b1;
    ra = q.drv_base;
    rwd = '0;
    rbe = BE_ALL;
    rwr = 1'b0;
    rd_adv = 1'b0;
    us_adv = 1'b0;
    us_step = 16'h0001;

    // one memory access in flight; a write ends at acceptance, a read at its response
    if (q.rq_v && mem_req_ready) begin
      d.rq_v = 1'b0;
      d.rs_w = ~q.rq.write;
      fin = q.rq.write;
    end
    if (q.rs_w && mem_rsp_valid) begin
      d.rs_w = 1'b0;
      fin = 1'b1;
    end

    case (q.st)
      S_IDLE: begin
        mst = 1'b0;
        if (en && q.bell) begin
          d.bell = 1'b0;
          d.st = pk ? S_DESC : S_IDX;
          d.w = W_FLAGS;
          d.cnt = '0;
          d.seen_wr = 1'b0;
        end
      end
      S_IDX: begin
        ra = q.drv_base;
        if (fin) begin
          d.avail_idx = dflags;
          // only slots below the driver's published index are ever fetched
          d.st = (dflags == rd_idx) ? S_IDLE : S_HEAD;
        end
      end
      S_HEAD: begin
        ra = ring_addr(q.drv_base, hslot);
        if (fin) begin
          d.head = half(mem_rdata, hslot[0]);
          d.bid = d.head;
          d.st = S_DESC;
          d.w = W_FLAGS;
          d.cnt = '0;
          d.seen_wr = 1'b0;
        end
      end
      S_DESC: begin
        ra = desc_addr(q.desc_base, pk ? rd_pos : q.head, q.w);
        if (fin) begin
          d.w = q.w + 2'h1;
          case (q.w)
            W_FLAGS: begin
              if (pk) begin
                d.fl = dflags;
                d.bid = mem_rdata[15:0];
                // not yet posted for this lap: wait for the next doorbell
                if (dflags[DESC_F_AVAIL_BIT] != rd_wrap ||
                    dflags[DESC_F_USED_BIT] == rd_wrap) begin
                  d.st = S_IDLE;
                end
              end else begin
                d.fl = mem_rdata[15:0];
                d.nxt = dflags;
              end
            end
            W_ADDR_LO: d.el.addr[31:0] = mem_rdata;
            W_ADDR_HI: d.el.addr[63:32] = mem_rdata;
            default: begin
              d.el.len = mem_rdata;
              d.el.write = (q.fl & DESC_F_WRITE) != '0;
              d.el.last = (q.fl & DESC_F_NEXT) == '0;
              d.el.id = q.bid;
              d.st = S_EMIT;
            end
          endcase
        end
      end
      S_EMIT: begin
        mst = 1'b0;
        if (elem_ready) begin
          d.cnt = q.cnt + 16'h0001;
          d.seen_wr = q.seen_wr | q.el.write;
          if (q.seen_wr && !q.el.write) begin
            d.err = 1'b1;
          end
          rd_adv = pk | q.el.last;
          d.w = W_FLAGS;
          if (q.el.last) begin
            d.st = S_WAIT;
          end else begin
            d.head = q.nxt;
            d.st = S_DESC;
          end
        end
      end
      S_WAIT: begin
        mst = 1'b0;
        if (done_valid) begin
          d.done_len = done_len;
          d.st = pk ? S_UW1 : S_UW0;
        end
      end
      S_UW0: begin
        ra = elem_addr(q.dev_base, slot(us_idx, q.qsize));
        rwd = {16'h0000, q.bid};
        rwr = 1'b1;
        if (fin) begin
          d.st = S_UW1;
        end
      end
      S_UW1: begin
        ra = pk ? desc_addr(q.desc_base, us_pos, W_LEN) :
                  elem_addr(q.dev_base, slot(us_idx, q.qsize)) + ELEM_LEN_OFF;
        rwd = q.done_len;
        rwr = 1'b1;
        if (fin) begin
          d.st = S_UIDX;
        end
      end
      S_UIDX: begin
        // flags word (packed) or used index (split) last, so the driver never sees a used mark before its length
        ra = pk ? desc_addr(q.desc_base, us_pos, W_FLAGS) : q.dev_base;
        rwd = pk ? {uflags, q.bid} : {us_idx + 16'h0001, 16'h0000};
        rbe = pk ? BE_ALL : BE_HI;
        rwr = 1'b1;
        if (fin) begin
          us_adv = 1'b1;
          us_step = pk ? q.cnt : 16'h0001;
          d.ev = us_idx;
          d.st = S_SUPP;
        end
      end
      S_SUPP: begin
        ra = (!pk && evt) ? ring_addr(q.drv_base, q.qsize) : q.drv_base;
        if (fin) begin
          if (pk) begin
            d.notify = mem_rdata[17:16] != SUPP_DISABLE;
          end else if (evt) begin
            d.notify = half(mem_rdata, q.qsize[0]) == q.ev;
          end else begin
            d.notify = ~mem_rdata[0];
          end
          d.st = pk ? S_DESC : S_IDX;
          d.w = W_FLAGS;
          d.cnt = '0;
          d.seen_wr = 1'b0;
        end
      end
      default: begin
        mst = 1'b0;
        d.st = S_IDLE;
      end
    endcase

    if (mst && !q.rq_v && !q.rs_w) begin
      d.rq.addr = ra;
      d.rq.wdata = rwd;
      d.rq.be = rbe;
      d.rq.write = rwr;
      d.rq_v = 1'b1;
    end

    // register writes follow the engine so a doorbell in a clearing cycle is kept
    if (reg_wr) begin
      case (reg_addr)
        OFF_CTRL: d.ctrl = reg_wdata[2:0];
        OFF_QSIZE: d.qsize = (reg_wdata > {16'h0000, QSIZE_MAX}) ? QSIZE_MAX :
                             reg_wdata[15:0];
        OFF_DESC_BASE: d.desc_base = reg_wdata;
        OFF_DRV_BASE: d.drv_base = reg_wdata;
        OFF_DEV_BASE: d.dev_base = reg_wdata;
        OFF_BELL: d.bell = 1'b1;
        default: d.bell = d.bell;
      endcase
    end

    d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFF_CTRL: d.rdata = {29'h0000_0000, q.ctrl};
        OFF_QSIZE: d.rdata = {16'h0000, q.qsize};
        OFF_DESC_BASE: d.rdata = q.desc_base;
        OFF_DRV_BASE: d.rdata = q.drv_base;
        OFF_DEV_BASE: d.rdata = q.dev_base;
        OFF_STATUS: d.rdata = {us_idx, rd_idx};
        OFF_STATE: d.rdata = {28'h000_0000, q.err, q.st != S_IDLE, us_wrap, rd_wrap};
        OFF_AVAIL: d.rdata = {16'h0000, q.avail_idx};
        default: d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.qsize <= QSIZE_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign mem_req_valid = q.rq_v;
  assign mem_req = q.rq;
  assign elem_valid = q.st == S_EMIT;
  assign elem = q.el;
  assign done_ready = q.st == S_WAIT;
  assign used_notify = q.notify;
endmodule // ring_engine

//--- ring_engine_props.sv
// port-level assertion checker for the ring engine
`timescale 1ns/1ps
module ring_engine_props (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic mem_req_valid,
  input wire ring_pkg::mem_req_type mem_req,
  input wire logic mem_req_ready,
  input wire logic mem_rsp_valid,
  input wire logic elem_valid,
  input wire ring_pkg::elem_type elem,
  input wire logic elem_ready,
  input wire logic done_valid,
  input wire logic done_ready,
  input wire logic used_notify
);
  import ring_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  sequence rd_acc_s;
    mem_req_valid && mem_req_ready && !mem_req.write;
  endsequence
  sequence rsp_wait_s;
    !mem_req_valid throughout ##[0:7] mem_rsp_valid;
  endsequence
  sequence done_s;
    done_valid && done_ready;
  endsequence
  req_hold_a: assert property (mem_req_valid && !mem_req_ready |=>
    mem_req_valid && $stable(mem_req)) else $error("memory request dropped or changed");
  rd_gap_a: assert property (rd_acc_s |=> rsp_wait_s)
    else $error("request issued while a read is outstanding");
  wr_gap_a: assert property (mem_req_valid && mem_req_ready && mem_req.write |=>
    !mem_req_valid) else $error("request right after a write");
  elem_hold_a: assert property (elem_valid && !elem_ready |=>
    elem_valid && $stable(elem)) else $error("element dropped or changed");
  done_excl_a: assert property (done_ready |-> !elem_valid)
    else $error("completion offered with an element pending");
  done_once_a: assert property (done_s |=> !done_ready)
    else $error("completion still open after it was taken");
  used_wr_a: assert property (done_s |-> ##[1:8] (mem_req_valid && mem_req.write))
    else $error("no used write after completion");
  notify_rsp_a: assert property (used_notify |-> $past(mem_rsp_valid))
    else $error("notification not after a response");
  notify_pulse_a: assert property (used_notify |=> !used_notify)
    else $error("notification longer than one cycle");
endmodule // ring_engine_props

bind ring_engine ring_engine_props ring_engine_props_i (.core_clk(core_clk), .rst_b(rst_b),
  .mem_req_valid(mem_req_valid), .mem_req(mem_req), .mem_req_ready(mem_req_ready),
  .mem_rsp_valid(mem_rsp_valid), .elem_valid(elem_valid), .elem(elem),
  .elem_ready(elem_ready), .done_valid(done_valid), .done_ready(done_ready),
  .used_notify(used_notify));

//--- ring_mem_model.sv
// shared-memory model of the driver side: rings and descriptors, answers device accesses
`timescale 1ns/1ps
module ring_mem_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic mem_req_valid,
  input wire ring_pkg::mem_req_type mem_req,
  output logic mem_req_ready,
  output logic mem_rsp_valid,
  output logic [31:0] mem_rdata
);
  import ring_pkg::*;
  logic [31:0] mem [0:255];
  logic [1:0] wait_q;
  logic [1:0] lat_q;
  logic [31:0] data_q;
  // a slow memory stalls acceptance as well as the answer
  assign mem_req_ready = mem_req_valid && wait_q == 2'h0;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 2'h0;
      lat_q <= 2'h0;
      mem_rsp_valid <= 1'b0;
      mem_rdata <= 32'h0000_0000;
    end else begin
      mem_rsp_valid <= 1'b0;
      // outside a response the data toggle, so a stale word is never mistaken for an answer
      mem_rdata <= ~mem_rdata;
      if (lat_q != 2'h0) lat_q <= lat_q - 2'h1;
      if (lat_q == 2'h1) begin
        mem_rsp_valid <= 1'b1;
        mem_rdata <= data_q;
      end
      if (mem_req_valid && wait_q != 2'h0) wait_q <= wait_q - 2'h1;
      if (mem_req_ready) begin
        wait_q <= slow ? 2'h2 : 2'h0;
        if (mem_req.write) begin
          for (int b = 0; b < 4; b++) begin
            if (mem_req.be[b]) mem[mem_req.addr[9:2]][8*b +: 8] <= mem_req.wdata[8*b +: 8];
          end
        end else begin
          data_q <= mem[mem_req.addr[9:2]];
          lat_q <= slow ? 2'h3 : 2'h1;
        end
      end
    end
  end
endmodule // ring_mem_model

//--- ring_types.sv
// shared types and constants of the ring engine, plus the ring cursor it uses
package ring_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_QSIZE = 8'h04;
  localparam logic [7:0] OFF_DESC_BASE = 8'h08;
  localparam logic [7:0] OFF_DRV_BASE = 8'h0c;
  localparam logic [7:0] OFF_DEV_BASE = 8'h10;
  localparam logic [7:0] OFF_BELL = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_STATE = 8'h1c;
  localparam logic [7:0] OFF_AVAIL = 8'h20;
  localparam int CTRL_EN = 0;
  localparam int CTRL_PACKED = 1;
  localparam int CTRL_EVT = 2;
  localparam logic [15:0] QSIZE_MAX = 16'h8000;
  localparam logic [15:0] QSIZE_RST = 16'h0100;
  localparam logic [15:0] DESC_F_NEXT = 16'h0001;
  localparam logic [15:0] DESC_F_WRITE = 16'h0002;
  localparam int DESC_F_AVAIL_BIT = 7;
  localparam int DESC_F_USED_BIT = 15;
  localparam logic [1:0] SUPP_DISABLE = 2'h1;
  localparam logic [1:0] W_ADDR_LO = 2'h0;
  localparam logic [1:0] W_ADDR_HI = 2'h1;
  localparam logic [1:0] W_LEN = 2'h2;
  localparam logic [1:0] W_FLAGS = 2'h3;
  localparam logic [3:0] BE_ALL = 4'hf;
  localparam logic [3:0] BE_HI = 4'hc;
  localparam logic [31:0] RING_HDR = 32'h0000_0004;
  localparam logic [31:0] ELEM_LEN_OFF = 32'h0000_0004;
  localparam logic WRAP_INIT = 1'b1;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_IDX = 4'h1,
    S_HEAD = 4'h3,
    S_DESC = 4'h2,
    S_EMIT = 4'h6,
    S_WAIT = 4'h7,
    S_UW0 = 4'h5,
    S_UW1 = 4'h4,
    S_UIDX = 4'hc,
    S_SUPP = 4'hd
  } st_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic write;
  } mem_req_type;

  typedef struct packed {
    logic [63:0] addr;
    logic [31:0] len;
    logic [15:0] id;
    logic write;
    logic last;
  } elem_type;

  function automatic logic [15:0] slot(input logic [15:0] idx, input logic [15:0] qsize);
    slot = idx & (qsize - 16'h0001);
  endfunction

  function automatic logic [15:0] half(input logic [31:0] word, input logic upper);
    half = upper ? word[31:16] : word[15:0];
  endfunction

  // word address of 16-bit entry i after the ring header
  function automatic logic [31:0] ring_addr(input logic [31:0] base, input logic [15:0] i);
    logic [31:0] a;
    a = base + RING_HDR + {15'h0000, i, 1'b0};
    ring_addr = {a[31:2], 2'b00};
  endfunction

  function automatic logic [31:0] desc_addr(input logic [31:0] base, input logic [15:0] i,
                                            input logic [1:0] w);
    desc_addr = base + {12'h000, i, 4'h0} + {28'h000_0000, w, 2'b00};
  endfunction

  function automatic logic [31:0] elem_addr(input logic [31:0] base, input logic [15:0] i);
    elem_addr = base + RING_HDR + {13'h0000, i, 3'b000};
  endfunction
endpackage

`timescale 1ns/1ps
module ring_cursor #(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic clr,
  input wire logic adv,
  input wire logic [W-1:0] step,
  input wire logic [W-1:0] qsize,
  output logic [W-1:0] idx,
  output logic [W-1:0] pos,
  output logic wrap
);
  import ring_pkg::*;
  typedef struct packed {
    logic [W-1:0] idx;
    logic [W-1:0] pos;
    logic wrap;
  } cur_type;
  cur_type q;
  cur_type d;
  logic [W:0] sum;

  always_comb begin
    d = q;
    sum = {1'b0, q.pos} + {1'b0, step};
    if (clr) begin
      d.idx = '0;
      d.pos = '0;
      d.wrap = WRAP_INIT;
    end else if (adv) begin
      d.idx = q.idx + step;
      if (sum >= {1'b0, qsize}) begin
        d.pos = W'(sum - {1'b0, qsize});
        d.wrap = ~q.wrap;
      end else begin
        d.pos = sum[W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q.idx <= '0;
      q.pos <= '0;
      q.wrap <= WRAP_INIT;
    end else if (ce) begin
      q <= d;
    end
  end

  assign idx = q.idx;
  assign pos = q.pos;
  assign wrap = q.wrap;
endmodule // ring_cursor
